// ---- rtl/diag_bank_pkg.sv ----
// shared constants and types of the fieldbus slave diagnostic bank
package diag_bank_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int HB_TIMEOUT_MS = 800;
  localparam int HB_TIMEOUT_CYC = HB_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int REFRESH_US = 1000;
  localparam int REFRESH_CYC = REFRESH_US * (CLK_HZ / 1_000_000);
  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_GC_FLAGS = 8'h94;
  localparam logic [7:0] IDX_GOOD_CNT = 8'h96;
  localparam logic [7:0] IDX_NET_CNT = 8'h97;
  localparam logic [7:0] IDX_TMO_CNT = 8'h98;
  localparam logic [7:0] IDX_CLR_CNT = 8'h9A;
  localparam logic [7:0] IDX_HB_CNT = 8'h9C;
  localparam logic [7:0] IDX_DIAG_LEN = 8'h9E;
  localparam logic [7:0] IDX_SLOT2 = 8'hA0;
  localparam logic [7:0] IDX_SLOT3 = 8'hA1;
  localparam logic [7:0] IDX_BUSADDR = 8'hA2;
  localparam logic [7:0] IDX_RECFG_CNT = 8'hA4;
  localparam logic [7:0] IDX_INIT_CNT = 8'hA5;
  localparam logic [7:0] IDX_FATAL = 8'hA6;
  localparam logic [7:0] IDX_PDO_TYPE = 8'hA8;
  localparam logic [7:0] IDX_RSVD_A9 = 8'hA9;
  localparam logic [7:0] IDX_SP_DESC = 8'hAA;
  localparam logic [7:0] IDX_ACT_DESC = 8'hAC;
  localparam logic [7:0] IDX_IRQ_STAT = 8'hD0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hD1;
  localparam logic [7:0] IDX_CTRL = 8'hD2;
  localparam logic [7:0] IDX_STATUS = 8'hD3;
  // dual-port RAM byte offsets read at run-up
  localparam logic [11:0] DP_SLOT2 = 12'h054;
  localparam logic [11:0] DP_SLOT3 = 12'h055;
  localparam logic [11:0] DP_BUSADDR = 12'h056;
  localparam logic [11:0] DP_SP_DESC = 12'h058;
  localparam logic [11:0] DP_ACT_DESC = 12'h05C;
  // interrupt status bit positions
  localparam int IRQ_GC = 0;
  localparam int IRQ_TMO = 1;
  localparam int IRQ_HB = 2;
  localparam int IRQ_FATAL = 3;
  localparam int IRQ_RECFG = 4;
  localparam int IRQ_RUNUP = 5;
  localparam int IRQ_W = 6;
  // control bits
  localparam int CTRL_RUNUP = 0;
  localparam int CTRL_SPDIAG = 1;
  localparam int CTRL_REFRESH = 2;
  localparam logic [2:0] CTRL_RST = 3'h4;
  // mirror fetch steps
  localparam logic [2:0] STEP_SLOT2 = 3'h0;
  localparam logic [2:0] STEP_SP = 3'h3;
  localparam logic [2:0] STEP_LAST = 3'h6;
  // one global-control telegram; bit 0 and bits 6..7 stay zero
  typedef struct packed {
    logic sync;
    logic unsync;
    logic freeze;
    logic unfreeze;
    logic clear_data;
  } gc_cmd_t;
  typedef struct packed {
    logic good_tlg;
    logic net_tlg;
    logic timeout;
    logic reconfig;
    logic init_run;
  } evt_t;
endpackage

// ---- rtl/heartbeat_watch.sv ----
// host heartbeat watchdog: flags a value that stays unchanged too long
`timescale 1ns/100ps
`default_nettype none
module heartbeat_watch
  import diag_bank_pkg::*;
#(
  parameter int TIMEOUT_CYC = HB_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // watched value and result
  input wire logic [7:0] hb_value,
  output logic hb_fail
);
  logic [31:0] cnt_q;
  logic [7:0] last_q;
  logic changed;
  logic expired;
  assign changed = (hb_value != last_q);
  assign expired = (cnt_q == 32'(TIMEOUT_CYC - 1));
  // restart after each failure so a stuck host counts once per period
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q <= 32'h0;
      last_q <= 8'h00;
      hb_fail <= 1'b0;
    end else begin
      last_q <= hb_value;
      hb_fail <= expired && !changed;
      cnt_q <= (changed || expired) ? 32'h0 : cnt_q + 32'h1;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/diag_bank.sv ----
// diagnostic register bank of the fieldbus slave board
// Functional notes
// - global-control flags hold until the next global-control telegram replaces them.
// - flag bits: 1 clear data, 2 unfreeze, 3 freeze, 4 unsync, 5 sync.
// - count error-free standard telegrams in a byte counter.
// - count received net telegrams beside the good telegram counter.
// - count response-monitoring timeouts.
// - count each recognised clear data command.
// - host must change heartbeat; unchanged about 800 ms advances error counter.
// - report diagnostic byte count during selected special diagnosis.
// - copy slot identifier bytes from RAM 054H and 055H at run-up.
// - count host reconfiguration requests made while online.
// - count every run through the initialisation routine.
// - record the error code of a fatal stack manager error.
// - store process-data object type decoded from configuration.
// - mirror setpoint and actual descriptors at run-up, then refresh cyclically.
`timescale 1ns/100ps
`default_nettype none
module diag_bank
  import diag_bank_pkg::*;
#(
  parameter int HB_CYC = HB_TIMEOUT_CYC,
  parameter int REFR_CYC = REFRESH_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // avalon-mm slave, word addressed
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // protocol side events
  input wire logic gc_valid,
  input wire gc_cmd_t gc_cmd,
  input wire evt_t evt,
  input wire logic online,
  input wire logic fatal_valid,
  input wire logic [7:0] fatal_code,
  input wire logic cfg_valid,
  input wire logic [7:0] pdo_type,
  input wire logic diag_len_valid,
  input wire logic [7:0] diag_len,
  input wire logic [7:0] hb_value,
  // dual-port ram read port, data one cycle after the strobe
  output logic dp_rd,
  output logic [11:0] dp_addr,
  input wire logic [7:0] dp_rdata,
  // interrupt
  output logic irq
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_REQ = 4'b0010,
    ST_DATA = 4'b0100,
    ST_WAIT = 4'b1000
  } fetch_st_t;

  function automatic logic [11:0] step_addr(input logic [2:0] s);
    case (s)
      3'h0: step_addr = DP_SLOT2;
      3'h1: step_addr = DP_SLOT3;
      3'h2: step_addr = DP_BUSADDR;
      3'h3: step_addr = DP_SP_DESC;
      3'h4: step_addr = DP_SP_DESC + 12'h1;
      3'h5: step_addr = DP_ACT_DESC;
      default: step_addr = DP_ACT_DESC + 12'h1;
    endcase
  endfunction

  logic [4:0] gc_q;
  logic [7:0] good_q, net_q, tmo_q, clr_q, hb_q, len_q, recfg_q, init_q;
  logic [7:0] fatal_q, pdo_q, slot2_q, slot3_q, busaddr_q;
  logic [15:0] sp_q, act_q;
  logic [IRQ_W-1:0] stat_q, mask_q;
  logic [2:0] ctrl_q;
  fetch_st_t st_q, st_d;
  logic [2:0] step_q, step_d;
  logic runup_q;
  logic runup_pend_q, runup_go, fetch_idle;
  logic [31:0] refr_q;
  logic hb_fail;
  logic wr_go, rd_go, runup_req, refr_tick, fetch_done;
  logic [31:0] rd_mux;
  logic [IRQ_W-1:0] ev_vec;

  heartbeat_watch #(.TIMEOUT_CYC(HB_CYC)) u_hb (
    .mclk(mclk),
    .rst(rst),
    .hb_value(hb_value),
    .hb_fail(hb_fail)
  );

  // a write is served in the cycle after waitrequest drops; read data is latched on the edge where it drops
  assign wr_go = write && !waitrequest;
  assign rd_go = read && waitrequest;

  // bus slave: one wait state per access
  always_ff @(posedge mclk) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
      if (rd_go) begin
        readdata <= rd_mux;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    case (address)
      IDX_GC_FLAGS: rd_mux = {26'h0, gc_q, 1'b0};
      IDX_GOOD_CNT: rd_mux = {24'h0, good_q};
      IDX_NET_CNT: rd_mux = {24'h0, net_q};
      IDX_TMO_CNT: rd_mux = {24'h0, tmo_q};
      IDX_CLR_CNT: rd_mux = {24'h0, clr_q};
      IDX_HB_CNT: rd_mux = {24'h0, hb_q};
      IDX_DIAG_LEN: rd_mux = {24'h0, len_q};
      IDX_SLOT2: rd_mux = {24'h0, slot2_q};
      IDX_SLOT3: rd_mux = {24'h0, slot3_q};
      IDX_BUSADDR: rd_mux = {24'h0, busaddr_q};
      IDX_RECFG_CNT: rd_mux = {24'h0, recfg_q};
      IDX_INIT_CNT: rd_mux = {24'h0, init_q};
      IDX_FATAL: rd_mux = {24'h0, fatal_q};
      IDX_PDO_TYPE: rd_mux = {24'h0, pdo_q};
      IDX_SP_DESC: rd_mux = {16'h0, sp_q};
      IDX_ACT_DESC: rd_mux = {16'h0, act_q};
      IDX_IRQ_STAT: rd_mux = {26'h0, stat_q};
      IDX_IRQ_MASK: rd_mux = {26'h0, mask_q};
      IDX_CTRL: rd_mux = {29'h0, ctrl_q};
      IDX_STATUS: rd_mux = {27'h0, st_q, runup_q};
      default: rd_mux = 32'h0;
    endcase
  end

  // control and mask registers; run-up bit self-clears
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
      mask_q <= '0;
    end else begin
      ctrl_q[CTRL_RUNUP] <= 1'b0;
      if (wr_go && address == IDX_CTRL) begin
        ctrl_q <= writedata[2:0];
      end
      if (wr_go && address == IDX_IRQ_MASK) begin
        mask_q <= writedata[IRQ_W-1:0];
      end
    end
  end

  // flags replaced only by a new telegram
  // clear data lands on gc_q bit 0, read back as register bit 1
  always_ff @(posedge mclk) begin
    if (rst) begin
      gc_q <= 5'h0;
    end else if (gc_valid) begin
      gc_q <= gc_cmd;
    end
  end

  // all counters wrap by plain addition
  always_ff @(posedge mclk) begin
    if (rst) begin
      good_q <= 8'h00;
      net_q <= 8'h00;
      tmo_q <= 8'h00;
      clr_q <= 8'h00;
      hb_q <= 8'h00;
      recfg_q <= 8'h00;
      init_q <= 8'h00;
    end else begin
      if (evt.good_tlg) good_q <= good_q + 8'h01;
      if (evt.net_tlg) net_q <= net_q + 8'h01;
      if (evt.timeout) tmo_q <= tmo_q + 8'h01;
      if (gc_valid && gc_cmd.clear_data) clr_q <= clr_q + 8'h01;
      if (hb_fail) hb_q <= hb_q + 8'h01;
      if (evt.reconfig && online) recfg_q <= recfg_q + 8'h01;
      if (runup_req) init_q <= init_q + 8'h01;
    end
  end

  // captured values from the protocol side
  always_ff @(posedge mclk) begin
    if (rst) begin
      fatal_q <= 8'h00;
      pdo_q <= 8'h00;
      len_q <= 8'h00;
    end else begin
      if (fatal_valid) fatal_q <= fatal_code;
      if (cfg_valid) pdo_q <= pdo_type;
      // only while special diagnosis is selected
      if (diag_len_valid && ctrl_q[CTRL_SPDIAG]) len_q <= diag_len;
    end
  end

  // initialisation runs at reset release, on request or from software
  assign runup_req = runup_q || evt.init_run || ctrl_q[CTRL_RUNUP];
  assign fetch_done = (st_q == ST_DATA) && (step_q == STEP_LAST);
  assign refr_tick = (refr_q == 32'(REFR_CYC - 1));
  // run-up asked for mid-fetch waits, so no byte lands in the wrong mirror
  assign fetch_idle = (st_q == ST_IDLE) || (st_q == ST_WAIT);
  assign runup_go = runup_req || runup_pend_q;
  assign step_d = fetch_idle ? (runup_go ? STEP_SLOT2 : STEP_SP) :
                  (st_q == ST_DATA) ? step_q + 3'h1 : step_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      runup_q <= 1'b1;
      refr_q <= 32'h0;
    end else begin
      runup_q <= 1'b0;
      refr_q <= (refr_tick || st_q != ST_WAIT) ? 32'h0 : refr_q + 32'h1;
    end
  end

  // mirror fetch sequencer; run-up reads all steps, refresh only descriptors
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: st_d = runup_go ? ST_REQ : ST_IDLE;
      ST_REQ: st_d = ST_DATA;
      ST_DATA: st_d = fetch_done ? ST_WAIT : ST_REQ;
      ST_WAIT: begin
        if (runup_go || (refr_tick && ctrl_q[CTRL_REFRESH])) begin
          st_d = ST_REQ;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= ST_IDLE;
      step_q <= STEP_SLOT2;
      runup_pend_q <= 1'b0;
      dp_rd <= 1'b0;
      dp_addr <= 12'h0;
    end else begin
      st_q <= st_d;
      step_q <= step_d;
      dp_rd <= (st_d == ST_REQ);
      // address follows the step being requested, not the one just read
      dp_addr <= step_addr(step_d);
      runup_pend_q <= runup_go && !fetch_idle;
    end
  end

  // mirrors are written in the cycle the ram data is valid
  always_ff @(posedge mclk) begin
    if (rst) begin
      slot2_q <= 8'h00;
      slot3_q <= 8'h00;
      busaddr_q <= 8'h00;
      sp_q <= 16'h0;
      act_q <= 16'h0;
    end else if (st_q == ST_DATA) begin
      case (step_q)
        3'h0: slot2_q <= dp_rdata;
        3'h1: slot3_q <= dp_rdata;
        3'h2: busaddr_q <= dp_rdata;
        3'h3: sp_q[7:0] <= dp_rdata;
        3'h4: sp_q[15:8] <= dp_rdata;
        3'h5: act_q[7:0] <= dp_rdata;
        default: act_q[15:8] <= dp_rdata;
      endcase
    end
  end

  // sticky events; a new event wins over a same-cycle clear
  assign ev_vec = {fetch_done, evt.reconfig && online, fatal_valid, hb_fail,
                   evt.timeout, gc_valid};
  always_ff @(posedge mclk) begin
    if (rst) begin
      stat_q <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_go && address == IDX_IRQ_STAT) begin
        stat_q <= (stat_q & ~writedata[IRQ_W-1:0]) | ev_vec;
      end else begin
        stat_q <= stat_q | ev_vec;
      end
      irq <= |(stat_q & mask_q);
    end
  end

  sequence s_clr_seen;
    gc_valid && gc_cmd.clear_data;
  endsequence
  sequence s_fetch_byte;
    st_q == ST_REQ ##1 st_q == ST_DATA;
  endsequence

  AST_GC_HOLD: assert property (@(posedge mclk) disable iff (rst)
    !gc_valid |=> $stable(gc_q)) else $error("flags changed without telegram");
  AST_GC_BIT: assert property (@(posedge mclk) disable iff (rst)
    s_clr_seen |=> gc_q[0]) else $error("clear data flag missing");
  AST_GOOD: assert property (@(posedge mclk) disable iff (rst)
    evt.good_tlg |=> good_q == $past(good_q) + 8'h01) else $error("good count");
  AST_NET: assert property (@(posedge mclk) disable iff (rst)
    !evt.net_tlg |=> net_q == $past(net_q)) else $error("net count moved");
  AST_TMO: assert property (@(posedge mclk) disable iff (rst)
    evt.timeout |=> tmo_q == $past(tmo_q) + 8'h01) else $error("timeout not counted");
  AST_CLR: assert property (@(posedge mclk) disable iff (rst)
    s_clr_seen |=> clr_q == $past(clr_q) + 8'h01) else $error("clear count");
  AST_HB: assert property (@(posedge mclk) disable iff (rst)
    hb_fail |=> hb_q == $past(hb_q) + 8'h01) else $error("heartbeat count");
  AST_LEN: assert property (@(posedge mclk) disable iff (rst)
    diag_len_valid && !ctrl_q[CTRL_SPDIAG] |=> $stable(len_q)) else $error("len w/o diag");
  AST_SLOT: assert property (@(posedge mclk) disable iff (rst)
    s_fetch_byte ##0 step_q == STEP_SLOT2 |=> slot2_q == $past(dp_rdata) &&
    $past(dp_addr, 2) == DP_SLOT2) else $error("slot mirror wrong");
  AST_RECFG: assert property (@(posedge mclk) disable iff (rst)
    evt.reconfig && !online |=> $stable(recfg_q)) else $error("offline reconfig counted");
  AST_FATAL: assert property (@(posedge mclk) disable iff (rst)
    fatal_valid |=> fatal_q == $past(fatal_code)) else $error("fatal code lost");
  AST_REFRESH: assert property (@(posedge mclk) disable iff (rst)
    st_q == ST_WAIT && refr_tick && ctrl_q[CTRL_REFRESH] |=> dp_rd)
    else $error("no cyclic refresh");
  AST_WRAP: assert property (@(posedge mclk) disable iff (rst)
    evt.good_tlg && good_q == 8'hFF |=> good_q == 8'h00) else $error("no wrap");
  AST_IRQ: assert property (@(posedge mclk) disable iff (rst)
    |(stat_q & mask_q) |=> irq) else $error("irq not raised");
endmodule
`default_nettype wire

// ---- dv/dual_port_ram_model.sv ----
// dual-port ram model of the host drive board side
`timescale 1ns/100ps
`default_nettype none
module dual_port_ram_model (
  // clock
  input wire logic mclk,
  // read port
  input wire logic dp_rd,
  input wire logic [11:0] dp_addr,
  output logic [7:0] dp_rdata,
  // content selector, lets the bench change the stored values
  input wire logic [7:0] salt
);
  initial dp_rdata = 8'hA5;
  // byte one cycle after strobe
  // no hold beyond that cycle: data flips so stale values never pass
  always @(posedge mclk) begin
    if (dp_rd) begin
      dp_rdata <= dp_addr[7:0] + salt;
    end else begin
      dp_rdata <= ~dp_rdata;
    end
  end
endmodule
`default_nettype wire

// ---- dv/tb_diag_bank.sv ----
// self-checking bench of the diagnostic register bank
`timescale 1ns/100ps
`default_nettype none
module tb_diag_bank import diag_bank_pkg::*;;
  typedef struct {logic [4:0] ev; logic [7:0] idx; logic on; int n; logic [31:0] exp;} row_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest, dp_rd, irq;
  logic [11:0] dp_addr;
  logic [7:0] dp_rdata;
  logic gc_valid = 1'b0, online = 1'b0, fatal_valid = 1'b0, cfg_valid = 1'b0;
  logic diag_len_valid = 1'b0, hb_run = 1'b1;
  gc_cmd_t gc_cmd = '0;
  evt_t evt = '0;
  logic [7:0] fatal_code = 8'h00, pdo_type = 8'h00, diag_len = 8'h00;
  logic [7:0] hb_value = 8'h00, salt = 8'h30;
  logic [31:0] v;
  int fails = 0, checks_done = 0, cycles = 0;
  row_t rows[6] = '{
    '{5'h10, IDX_GOOD_CNT, 1'b0, 3, 32'h3},
    '{5'h08, IDX_NET_CNT, 1'b0, 2, 32'h2},
    '{5'h04, IDX_TMO_CNT, 1'b0, 4, 32'h4},
    '{5'h02, IDX_RECFG_CNT, 1'b0, 2, 32'h0},
    '{5'h02, IDX_RECFG_CNT, 1'b1, 2, 32'h2},
    '{5'h01, IDX_INIT_CNT, 1'b0, 1, 32'h2}};

  diag_bank #(.HB_CYC(50), .REFR_CYC(20)) dut_u (
    .mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .gc_valid(gc_valid), .gc_cmd(gc_cmd), .evt(evt), .online(online),
    .fatal_valid(fatal_valid), .fatal_code(fatal_code), .cfg_valid(cfg_valid),
    .pdo_type(pdo_type), .diag_len_valid(diag_len_valid), .diag_len(diag_len),
    .hb_value(hb_value), .dp_rd(dp_rd), .dp_addr(dp_addr), .dp_rdata(dp_rdata), .irq(irq));
  dual_port_ram_model ram_u (.mclk(mclk), .dp_rd(dp_rd), .dp_addr(dp_addr), .dp_rdata(dp_rdata),
    .salt(salt));

  always #10 mclk = ~mclk;
  // host heartbeat changes every cycle while running
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (hb_run) begin
      hb_value <= hb_value + 8'h01;
    end
    if (cycles == 30000) begin
      fails = fails + 1;
      stop_test();
    end
  end

  function automatic logic [7:0] ram_byte(input logic [11:0] a, input logic [7:0] s);
    return a[7:0] + s;
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      fails = fails + 1;
    end
  endtask
  // request held until waitrequest is sampled low
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    read <= 1'b1;
    address <= a;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    write <= 1'b1;
    address <= a;
    writedata <= d;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus_rd(a, d);
    chk(name, exp, d);
  endtask
  // descriptors are mirrored low byte first
  task automatic chk_desc(input logic [7:0] a, input logic [11:0] off, input logic [7:0] s);
    logic [31:0] d;
    bus_rd(a, d);
    chk("descriptor", {16'h0, ram_byte(off + 12'h001, s), ram_byte(off, s)}, d);
  endtask
  // one-cycle strobe: 0 events, 1 global control, 2 fatal, 3 config, 4 diag length
  task automatic strobe(input logic [2:0] k, input logic [7:0] d);
    @(posedge mclk);
    evt <= (k == 3'h0) ? evt_t'(d[4:0]) : '0;
    {gc_valid, fatal_valid, cfg_valid, diag_len_valid} <= {k == 3'h1, k == 3'h2, k == 3'h3, k == 3'h4};
    gc_cmd <= gc_cmd_t'(d[4:0]);
    fatal_code <= d;
    pdo_type <= d;
    diag_len <= d;
    @(posedge mclk);
    evt <= '0;
    {gc_valid, fatal_valid, cfg_valid, diag_len_valid} <= 4'h0;
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    chk("waitrequest_in_reset", 32'h1, {31'h0, waitrequest});
    rst <= 1'b0;
    rd_chk("ctrl", IDX_CTRL, 32'h4);
    rd_chk("gc_flags", IDX_GC_FLAGS, 32'h0);
    rd_chk("unmapped", 8'h40, 32'h0);
    for (int k = 0; k < 20; k++) begin
      bus_rd(IDX_IRQ_STAT, v);
      if (v[IRQ_RUNUP] === 1'b1) break;
    end
    rd_chk("init_count", IDX_INIT_CNT, 32'h1);
    rd_chk("slot2", IDX_SLOT2, {24'h0, ram_byte(DP_SLOT2, 8'h30)});
    rd_chk("slot3", IDX_SLOT3, {24'h0, ram_byte(DP_SLOT3, 8'h30)});
    chk_desc(IDX_SP_DESC, DP_SP_DESC, 8'h30);
    chk_desc(IDX_ACT_DESC, DP_ACT_DESC, 8'h30);
    foreach (rows[i]) begin
      @(posedge mclk);
      online <= rows[i].on;
      repeat (rows[i].n) strobe(3'h0, {3'h0, rows[i].ev});
      rd_chk("event_count", rows[i].idx, rows[i].exp);
    end
    repeat (253) strobe(3'h0, 8'h10);
    rd_chk("good_wrap", IDX_GOOD_CNT, 32'h0);
    bus_wr(IDX_GOOD_CNT, 32'hFF);
    rd_chk("good_ro", IDX_GOOD_CNT, 32'h0);
    // refresh picks up new ram contents, slot mirror does not
    @(posedge mclk);
    salt <= 8'h60;
    for (int k = 0; k < 20; k++) begin
      bus_rd(IDX_ACT_DESC, v);
      if (v[7:0] !== ram_byte(DP_ACT_DESC, 8'h30) && v[7:0] !== ram_byte(12'h05D, 8'h30)) break;
    end
    chk_desc(IDX_ACT_DESC, DP_ACT_DESC, 8'h60);
    chk_desc(IDX_SP_DESC, DP_SP_DESC, 8'h60);
    rd_chk("slot2_kept", IDX_SLOT2, {24'h0, ram_byte(DP_SLOT2, 8'h30)});
    for (int i = 0; i < 5; i++) begin
      strobe(3'h1, 8'(1 << i));
      rd_chk("gc_flags", IDX_GC_FLAGS, 32'(2 << i));
    end
    strobe(3'h0, 8'h10);
    rd_chk("gc_hold", IDX_GC_FLAGS, 32'h20);
    strobe(3'h1, 8'h11);
    rd_chk("gc_both", IDX_GC_FLAGS, 32'h22);
    rd_chk("clear_count", IDX_CLR_CNT, 32'h2);
    rd_chk("hb_count", IDX_HB_CNT, 32'h0);
    @(posedge mclk);
    hb_run <= 1'b0;
    repeat (120) @(posedge mclk);
    rd_chk("hb_count_stall", IDX_HB_CNT, 32'h2);
    hb_run <= 1'b1;
    strobe(3'h4, 8'h11);
    rd_chk("diag_len_off", IDX_DIAG_LEN, 32'h0);
    bus_wr(IDX_CTRL, 32'h6);
    strobe(3'h4, 8'h11);
    rd_chk("diag_len", IDX_DIAG_LEN, 32'h11);
    strobe(3'h2, 8'hC3);
    strobe(3'h3, 8'h05);
    bus_wr(IDX_FATAL, 32'h0);
    bus_wr(IDX_RSVD_A9, 32'hFF);
    rd_chk("fatal", IDX_FATAL, 32'hC3);
    rd_chk("pdo_type", IDX_PDO_TYPE, 32'h5);
    rd_chk("reserved", IDX_RSVD_A9, 32'h0);
    bus_wr(IDX_IRQ_MASK, 32'h0);
    bus_wr(IDX_IRQ_STAT, 32'h3F);
    strobe(3'h0, 8'h04);
    bus_rd(IDX_IRQ_STAT, v);
    chk("irq_stat", 32'h2, {27'h0, v[4:0]});
    chk("irq_masked", 32'h0, {31'h0, irq});
    bus_wr(IDX_IRQ_MASK, 32'h2);
    repeat (3) @(posedge mclk);
    chk("irq_on", 32'h1, {31'h0, irq});
    bus_wr(IDX_IRQ_STAT, 32'h2);
    repeat (3) @(posedge mclk);
    chk("irq_off", 32'h0, {31'h0, irq});
    rd_chk("timeout_count", IDX_TMO_CNT, 32'h5);
    // mid-run reset clears counters and reruns the fetch
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd_chk("init_after_rst", IDX_INIT_CNT, 32'h1);
    rd_chk("tmo_after_rst", IDX_TMO_CNT, 32'h0);
    rd_chk("ctrl_after_rst", IDX_CTRL, 32'h4);
    stop_test();
  end
endmodule
`default_nettype wire
